// ==== hw/fpid_top.sv ====
// Power-down, ready/busy routing and ID readout for a serial NOR flash.
// Assumes sclk_in runs only while cs_n_in is low, and that wip_in and
// soft_reset_in come from the program/erase and reset logic on clk_in.
`timescale 1ns/10ps
module fpid_top #(
    parameter logic [7:0] MAKER_ID = 8'h5A,      // Arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h3C,     // Arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h61,      // Arbitrary value
    parameter logic [7:0] CAPACITY = 8'h15,      // Arbitrary value
    parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF_FEDCBA9876543210, // Arbitrary
    parameter int TMR_W = 16,
    parameter int PWRUP_CYC = fpid_pkg::FPID_PWRUP_CYC,
    parameter int DP_CYC = fpid_pkg::FPID_DP_CYC,
    parameter int RES1_CYC = fpid_pkg::FPID_RES1_CYC,
    parameter int RES2_CYC = fpid_pkg::FPID_RES2_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_out,
    input wire logic wip_in,
    input wire logic soft_reset_in,
    output logic deep_powerdown_out,
    output logic cmd_accept_out
);
    import fpid_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    fpid_state_t state_reg;
    logic [TMR_W-1:0] tmr_reg;
    logic busy_en_reg;
    logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
    logic blk_reg, dpd_reg, wip_reg;
    logic frame_end, ready;
    logic [7:0] cnt_reg, op_reg;
    logic len8_reg, id_seen_reg, swap_reg, go_reg;
    logic blk_s1_reg, blk_lk_reg, dpd_s1_reg, dpd_lk_reg, wip_s1_reg, wip_lk_reg;
    logic [7:0] op_full, cur_op, hdr;
    logic cur_ok, go_cond;
    logic [7:0] pos_reg, tx_len, tx_lanes, pos_sum, idx;
    logic [127:0] tx_word;
    logic [3:0] tx_bits, tx_d, tx_oe;
    logic [3:0] lk_d_reg, lk_oe_reg;
    logic [TMR_W-1:0] dwell_reg;

    // ---------------------------------------------------------------
    // Link side: command shifter on rising serial clock
    // ---------------------------------------------------------------
    always_comb begin
        op_full = {op_reg[6:0], io_in[0]};
        cur_op = (cnt_reg == FPID_LAST_OP_CLK) ? op_full : op_reg;
        hdr = fpid_hdr(cur_op);
        if (cur_op == FPID_OP_RELEASE) begin
            cur_ok = !wip_lk_reg && (!blk_lk_reg || dpd_lk_reg);
        end else if (cur_op == FPID_OP_IDENT3) begin
            cur_ok = !wip_lk_reg && !blk_lk_reg;
        end else begin
            cur_ok = !blk_lk_reg;
        end
        go_cond = (hdr != 8'h00) && (cnt_reg == hdr - 8'h01) && cur_ok;
    end

    // Chip select high clears the frame at once, no clock needed
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            cnt_reg <= 8'h00;
            go_reg <= 1'b0;
        end else begin
            if (cnt_reg != FPID_CNT_MAX) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
            if (go_cond) begin
                go_reg <= 1'b1;
            end
        end
    end

    // Frame summary survives the rise of chip select for the system side
    always_ff @(posedge sclk_in) begin
        if (cnt_reg < FPID_HDR_IDENT3) begin
            op_reg <= op_full;
        end
        len8_reg <= (cnt_reg == FPID_LAST_OP_CLK);
        if (cnt_reg == 8'h00) begin
            id_seen_reg <= 1'b0;
        end else if (go_cond && cur_op == FPID_OP_RELEASE) begin
            id_seen_reg <= 1'b1;
        end
        if (go_cond) begin
            swap_reg <= io_in[0];
        end
    end

    // Power state into the serial domain; stale for two edges, long before decode
    always_ff @(posedge sclk_in) begin
        blk_s1_reg <= blk_reg;
        blk_lk_reg <= blk_s1_reg;
        dpd_s1_reg <= dpd_reg;
        dpd_lk_reg <= dpd_s1_reg;
        wip_s1_reg <= wip_reg;
        wip_lk_reg <= wip_s1_reg;
    end

    // ---------------------------------------------------------------
    // Link side: ID output on falling serial clock
    // ---------------------------------------------------------------
    always_comb begin
        tx_len = fpid_len(op_reg);
        tx_lanes = fpid_lanes(op_reg);
        case (op_reg)
            FPID_OP_RELEASE: tx_word = {120'h0, DEVICE_ID};
            FPID_OP_IDENT3: tx_word = {104'h0, MAKER_ID, MEM_TYPE, CAPACITY};
            FPID_OP_UID: tx_word = UNIQUE_ID;
            default: begin
                tx_word = swap_reg ? {112'h0, DEVICE_ID, MAKER_ID}
                                   : {112'h0, MAKER_ID, DEVICE_ID};
            end
        endcase
        tx_bits = 4'h0;
        for (int j = 0; j < 4; j++) begin
            idx = tx_len - pos_reg - tx_lanes + 8'(j);
            tx_bits[j] = tx_word[idx[6:0]];
        end
        if (tx_lanes == 8'h04) begin
            tx_d = tx_bits;
            tx_oe = FPID_OE_QUAD;
        end else if (tx_lanes == 8'h02) begin
            tx_d = {2'b00, tx_bits[1:0]};
            tx_oe = FPID_OE_DUAL;
        end else begin
            tx_d = {2'b00, tx_bits[0], 1'b0};
            tx_oe = FPID_OE_SINGLE;
        end
        pos_sum = pos_reg + tx_lanes;
    end

    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            lk_d_reg <= 4'h0;
            lk_oe_reg <= 4'h0;
            pos_reg <= 8'h00;
        end else if (go_reg) begin
            lk_d_reg <= tx_d;
            lk_oe_reg <= tx_oe;
            pos_reg <= (pos_sum >= tx_len) ? 8'h00 : pos_sum;
        end
    end

    // ---------------------------------------------------------------
    // System side: chip select crossing
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_n_in;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end

    // Serial clock is stopped once select is high, so the summary is steady here
    assign frame_end = cs_s2_reg && !cs_s3_reg;

    // ---------------------------------------------------------------
    // System side: power state and delays
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= FPID_ST_PWRUP;
            tmr_reg <= TMR_W'(PWRUP_CYC - 1);
        end else if (soft_reset_in) begin
            state_reg <= FPID_ST_NORMAL;
            tmr_reg <= '0;
        end else begin
            case (state_reg)
                FPID_ST_PWRUP: begin
                    if (tmr_reg == '0) begin
                        state_reg <= FPID_ST_NORMAL;
                    end else begin
                        tmr_reg <= tmr_reg - 1'b1;
                    end
                end
                FPID_ST_NORMAL: begin
                    if (frame_end && len8_reg && op_reg == FPID_OP_DPD && !wip_in) begin
                        state_reg <= FPID_ST_ENTER;
                        tmr_reg <= TMR_W'(DP_CYC - 1);
                    end
                end
                FPID_ST_ENTER: begin
                    if (tmr_reg == '0) begin
                        state_reg <= FPID_ST_DPD;
                    end else begin
                        tmr_reg <= tmr_reg - 1'b1;
                    end
                end
                FPID_ST_DPD: begin
                    if (frame_end && op_reg == FPID_OP_RELEASE && !wip_in) begin
                        if (len8_reg) begin
                            state_reg <= FPID_ST_EXIT;
                            tmr_reg <= TMR_W'(RES1_CYC - 1);
                        end else if (id_seen_reg) begin
                            state_reg <= FPID_ST_EXIT;
                            tmr_reg <= TMR_W'(RES2_CYC - 1);
                        end
                    end
                end
                FPID_ST_EXIT: begin
                    if (tmr_reg == '0) begin
                        state_reg <= FPID_ST_NORMAL;
                    end else begin
                        tmr_reg <= tmr_reg - 1'b1;
                    end
                end
                default: state_reg <= FPID_ST_NORMAL;
            endcase
        end
    end

    // Busy-output mode is volatile and is dropped by a software reset
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || soft_reset_in) begin
            busy_en_reg <= 1'b0;
        end else if (frame_end && len8_reg && state_reg == FPID_ST_NORMAL) begin
            if (op_reg == FPID_OP_BUSY_EN) begin
                busy_en_reg <= 1'b1;
            end else if (op_reg == FPID_OP_BUSY_DIS) begin
                busy_en_reg <= 1'b0;
            end
        end
    end

    // Levels for the serial domain, each from a flip-flop
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            blk_reg <= 1'b1;
            dpd_reg <= 1'b0;
            wip_reg <= 1'b0;
        end else begin
            blk_reg <= (state_reg != FPID_ST_NORMAL);
            dpd_reg <= (state_reg == FPID_ST_DPD);
            wip_reg <= wip_in;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Ready only in standby; deep power-down reads as busy too
    assign ready = (state_reg == FPID_ST_NORMAL) && !wip_in;
    assign io_oe_out = lk_oe_reg | {2'b00, busy_en_reg && cs_s2_reg, 1'b0};
    assign io_out = lk_d_reg | {2'b00, busy_en_reg && cs_s2_reg && ready, 1'b0};
    assign deep_powerdown_out = (state_reg == FPID_ST_DPD);
    assign cmd_accept_out = (state_reg == FPID_ST_NORMAL);

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || state_reg != FPID_ST_ENTER) begin
            dwell_reg <= '0;
        end else begin
            dwell_reg <= dwell_reg + 1'b1;
        end
    end

    property p_dp_enter;
        @(posedge clk_in) disable iff (!rst_n_in)
        frame_end && len8_reg && op_reg == FPID_OP_DPD && !wip_in && !soft_reset_in
            && state_reg == FPID_ST_NORMAL |=> state_reg == FPID_ST_ENTER;
    endproperty
    a_dp_enter: assert property (p_dp_enter) else $error("power-down not started");

    property p_dp_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        state_reg == FPID_ST_ENTER && dwell_reg < TMR_W'(DP_CYC - 1) && !soft_reset_in
            |=> state_reg == FPID_ST_ENTER;
    endproperty
    a_dp_hold: assert property (p_dp_hold) else $error("power-down entered early");

    property p_dp_done;
        @(posedge clk_in) disable iff (!rst_n_in)
        state_reg == FPID_ST_ENTER && dwell_reg == TMR_W'(DP_CYC - 1) && !soft_reset_in
            |=> state_reg == FPID_ST_DPD;
    endproperty
    a_dp_done: assert property (p_dp_done) else $error("power-down entry late");

    property p_dp_wip;
        @(posedge clk_in) disable iff (!rst_n_in)
        frame_end && op_reg == FPID_OP_DPD && wip_in && state_reg == FPID_ST_NORMAL
            && !soft_reset_in |=> state_reg == FPID_ST_NORMAL;
    endproperty
    a_dp_wip: assert property (p_dp_wip) else $error("power-down taken during cycle");

    property p_dp_len;
        @(posedge clk_in) disable iff (!rst_n_in)
        frame_end && !len8_reg && state_reg == FPID_ST_NORMAL && !soft_reset_in
            |=> state_reg == FPID_ST_NORMAL && busy_en_reg == $past(busy_en_reg);
    endproperty
    a_dp_len: assert property (p_dp_len) else $error("short or long frame executed");

    property p_busy_on;
        @(posedge clk_in) disable iff (!rst_n_in)
        frame_end && len8_reg && op_reg == FPID_OP_BUSY_EN && state_reg == FPID_ST_NORMAL
            && !soft_reset_in ##1 cs_s2_reg |-> io_oe_out[1] && io_out[1] == ready;
    endproperty
    a_busy_on: assert property (p_busy_on) else $error("ready/busy not shown");

    property p_busy_off;
        @(posedge clk_in) disable iff (!rst_n_in)
        frame_end && len8_reg && op_reg == FPID_OP_BUSY_DIS && state_reg == FPID_ST_NORMAL
            |=> !busy_en_reg && (!cs_s2_reg || io_oe_out == 4'h0);
    endproperty
    a_busy_off: assert property (p_busy_off) else $error("ready/busy still shown");

    property p_dpd_only_release;
        @(posedge clk_in) disable iff (!rst_n_in)
        state_reg == FPID_ST_DPD && frame_end && op_reg != FPID_OP_RELEASE && !soft_reset_in
            |=> state_reg == FPID_ST_DPD && !cmd_accept_out;
    endproperty
    a_dpd_only_release: assert property (p_dpd_only_release) else $error("command in power-down");

    property p_release_wip;
        @(posedge clk_in) disable iff (!rst_n_in)
        state_reg == FPID_ST_DPD && frame_end && wip_in && !soft_reset_in
            |=> state_reg == FPID_ST_DPD;
    endproperty
    a_release_wip: assert property (p_release_wip) else $error("release taken during cycle");

    property p_release_go;
        @(posedge clk_in) disable iff (!rst_n_in)
        state_reg == FPID_ST_DPD && frame_end && len8_reg && op_reg == FPID_OP_RELEASE
            && !wip_in && !soft_reset_in |=> state_reg == FPID_ST_EXIT ##1 !cmd_accept_out;
    endproperty
    a_release_go: assert property (p_release_go) else $error("release not started");

    property p_idle_quiet;
        @(posedge clk_in) disable iff (!rst_n_in)
        cs_s2_reg && !busy_en_reg |-> io_oe_out == 4'h0;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pins driven while deselected");

    property p_ident_single;
        @(posedge sclk_in) disable iff (cs_n_in)
        go_reg && op_reg == FPID_OP_IDENT3 |-> lk_oe_reg == FPID_OE_SINGLE;
    endproperty
    a_ident_single: assert property (p_ident_single) else $error("ident lanes wrong");

    property p_quad_lanes;
        @(posedge sclk_in) disable iff (cs_n_in)
        go_reg && op_reg == FPID_OP_MD_QUAD |-> lk_oe_reg == FPID_OE_QUAD;
    endproperty
    a_quad_lanes: assert property (p_quad_lanes) else $error("quad ID lanes wrong");

    property p_dual_lanes;
        @(posedge sclk_in) disable iff (cs_n_in)
        go_reg && op_reg == FPID_OP_MD_DUAL |-> lk_oe_reg == FPID_OE_DUAL;
    endproperty
    a_dual_lanes: assert property (p_dual_lanes) else $error("dual ID lanes wrong");

    c_dp_cycle: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        state_reg == FPID_ST_ENTER ##[1:1000] state_reg == FPID_ST_DPD);
    c_release: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        state_reg == FPID_ST_EXIT ##[1:1000] state_reg == FPID_ST_NORMAL);
    c_busy_show: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        busy_en_reg && cs_s2_reg && !ready);
    c_uid_out: cover property (@(posedge sclk_in) disable iff (cs_n_in)
        go_reg && op_reg == FPID_OP_UID);

endmodule

// ==== hw/fpid_pkg.sv ====
// Constants, state type and decode helpers for the flash power-down and ID command block.
// Assumes one system clock at 200 MHz and a serial clock from the host, MSB first framing.
//
// What this block does
// - Busy-output enable shows ready/busy on output line
// - Busy-output disable stops ready/busy on output line
// - Busy commands need chip select rise after bit eight
// - Deep power-down entered after entry delay via opcode
// - In deep power-down only release or reset work
// - Power-down opcode needs chip select rise after eight
// - Power-down opcode rejected while write cycle runs
// - Chip select high gives standby, not deep power-down
// - Bare release opcode exits after first release delay
// - Release with dummies streams device ID repeatedly
// - Release opcode ignored while write in progress
// - Maker/device ID returns maker then device byte
// - Address bit zero set swaps ID byte order
// - Dual maker/device ID uses two data lines
// - Quad maker/device ID uses four data lines
// - Three-byte ident sends maker, type, capacity
// - Three-byte ident not decoded during write cycle
// - Chip select rise ends ID output, standby
// - Unique-ID opcode streams fixed 128-bit identifier
// - Write-in-progress high only while cycle runs; this block does not make it, it only samples wip_in from outside
package fpid_pkg;

    // ---------------------------------------------------------------
    // Opcodes
    // ---------------------------------------------------------------
    localparam logic [7:0] FPID_OP_BUSY_EN = 8'h70;
    localparam logic [7:0] FPID_OP_BUSY_DIS = 8'h80;
    localparam logic [7:0] FPID_OP_DPD = 8'hB9;
    localparam logic [7:0] FPID_OP_RELEASE = 8'hAB;
    localparam logic [7:0] FPID_OP_MD_ID = 8'h90;
    localparam logic [7:0] FPID_OP_MD_DUAL = 8'h92;
    localparam logic [7:0] FPID_OP_MD_QUAD = 8'h94;
    localparam logic [7:0] FPID_OP_IDENT3 = 8'h9F;
    localparam logic [7:0] FPID_OP_UID = 8'h4B;

    // ---------------------------------------------------------------
    // Frame layout in serial clocks
    // ---------------------------------------------------------------
    localparam logic [7:0] FPID_LAST_OP_CLK = 8'h07;
    localparam logic [7:0] FPID_CNT_MAX = 8'hFF;
    localparam logic [7:0] FPID_HDR_RELEASE = 8'h20;
    localparam logic [7:0] FPID_HDR_MD = 8'h20;
    localparam logic [7:0] FPID_HDR_MD_DUAL = 8'h14;
    localparam logic [7:0] FPID_HDR_MD_QUAD = 8'h0E;
    localparam logic [7:0] FPID_HDR_IDENT3 = 8'h08;
    localparam logic [7:0] FPID_HDR_UID = 8'h28;
    localparam logic [7:0] FPID_LEN_RELEASE = 8'h08;
    localparam logic [7:0] FPID_LEN_MD = 8'h10;
    localparam logic [7:0] FPID_LEN_IDENT3 = 8'h18;
    localparam logic [7:0] FPID_LEN_UID = 8'h80;
    localparam logic [3:0] FPID_OE_SINGLE = 4'h2;
    localparam logic [3:0] FPID_OE_DUAL = 4'h3;
    localparam logic [3:0] FPID_OE_QUAD = 4'hF;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int FPID_CLK_MHZ = 200;
    localparam int FPID_T_PWRUP_NS = 1000;
    localparam int FPID_T_DP_NS = 3000;
    localparam int FPID_T_RES1_NS = 3000;
    localparam int FPID_T_RES2_NS = 1800;

    // Least times round up, never below one cycle
    function automatic int fpid_cycles(input int t_ns);
        int c;
        c = (t_ns * FPID_CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int FPID_PWRUP_CYC = fpid_cycles(FPID_T_PWRUP_NS);
    localparam int FPID_DP_CYC = fpid_cycles(FPID_T_DP_NS);
    localparam int FPID_RES1_CYC = fpid_cycles(FPID_T_RES1_NS);
    localparam int FPID_RES2_CYC = fpid_cycles(FPID_T_RES2_NS);

    // ---------------------------------------------------------------
    // Power state
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        FPID_ST_PWRUP = 3'b000,
        FPID_ST_NORMAL = 3'b001,
        FPID_ST_ENTER = 3'b011,
        FPID_ST_DPD = 3'b010,
        FPID_ST_EXIT = 3'b110
    } fpid_state_t;

    // ---------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------
    // Clocks before data; zero means not an ID opcode
    function automatic logic [7:0] fpid_hdr(input logic [7:0] op);
        case (op)
            FPID_OP_RELEASE: return FPID_HDR_RELEASE;
            FPID_OP_MD_ID: return FPID_HDR_MD;
            FPID_OP_MD_DUAL: return FPID_HDR_MD_DUAL;
            FPID_OP_MD_QUAD: return FPID_HDR_MD_QUAD;
            FPID_OP_IDENT3: return FPID_HDR_IDENT3;
            FPID_OP_UID: return FPID_HDR_UID;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] fpid_len(input logic [7:0] op);
        case (op)
            FPID_OP_RELEASE: return FPID_LEN_RELEASE;
            FPID_OP_IDENT3: return FPID_LEN_IDENT3;
            FPID_OP_UID: return FPID_LEN_UID;
            default: return FPID_LEN_MD;
        endcase
    endfunction

    function automatic logic [7:0] fpid_lanes(input logic [7:0] op);
        case (op)
            FPID_OP_MD_DUAL: return 8'h02;
            FPID_OP_MD_QUAD: return 8'h04;
            default: return 8'h01;
        endcase
    endfunction

endpackage

// ==== tb/fpid_host.sv ====
// Host model: drives select, serial clock and data in; captures device data.
// Assumes one frame at a time; the serial clock is still outside frames.
`timescale 1ns/10ps
module fpid_host (
    output logic sclk_out,
    output logic cs_n_out,
    output logic [3:0] io_out,
    input wire logic [3:0] dev_io_in,
    input wire logic [3:0] dev_oe_in
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        io_out = 4'h0;
    end
    // Released data lines toggle, so a stale value is never mistaken for data
    task automatic frame(input logic [7:0] op, input int nclk, nhdr, ln, input logic a0,
            output logic [127:0] got, output logic oe);
        got = '0;
        oe = 1'b0;
        #13.7 cs_n_out = 1'b0;
        for (int i = 0; i < nclk; i++) begin
            io_out = (i < 8) ? {3'h0, op[7 - i]} :
                (i < nhdr) ? {3'h0, a0 && i == nhdr - 1} : ~io_out;
            #32 sclk_out = 1'b1;
            oe |= dev_oe_in[1];
            if (i >= nhdr) begin
                // An undriven lane reads inverted, so a missing enable shows as bad data
                got = ln == 4 ? {got[123:0], dev_io_in ~^ dev_oe_in} :
                    ln == 2 ? {got[125:0], dev_io_in[1:0] ~^ dev_oe_in[1:0]} :
                    {got[126:0], dev_io_in[1] ~^ dev_oe_in[1]};
            end
            #32 sclk_out = 1'b0;
        end
        #32 cs_n_out = 1'b1;
        io_out = ~io_out;
        #200;
    endtask
endmodule

// ==== tb/fpid_top_bench.sv ====
// Bench for the power-down, ready/busy and ID block.
// Assumes fpid_host as the host; short delay parameters keep the run brief.
`timescale 1ns/10ps
module fpid_top_bench;
    localparam logic [7:0] MK = 8'hC5; // Arbitrary value
    localparam logic [7:0] DV = 8'h2E; // Arbitrary value
    localparam logic [127:0] UID = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
    localparam logic [7:0] MT = 8'h47; // Arbitrary value
    localparam logic [7:0] CP = 8'h16; // Arbitrary value
    logic clk = 1'b0, rst_n = 1'b0, write_in_progress_flag = 1'b0, srst = 1'b0;
    logic sclk, cs_n, dpd, acc, a0, oe_s;
    logic [3:0] hio, io, oe;
    logic [127:0] got;
    int err_total = 0, comparisons = 0, cyc = 0, j, nd;
    logic [7:0] ops [6] = '{8'h90, 8'h92, 8'h94, 8'h9F, 8'hAB, 8'h4B};
    int hd [6] = '{32, 20, 14, 8, 32, 40};
    int dc [6] = '{32, 16, 8, 32, 16, 128};
    int ln [6] = '{1, 2, 4, 1, 1, 1};
    int ll [6] = '{16, 16, 16, 24, 8, 128};
    fpid_top #(.MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(MT), .CAPACITY(CP),
        .UNIQUE_ID(UID), .PWRUP_CYC(6), .DP_CYC(8), .RES1_CYC(60), .RES2_CYC(50)) i_dut (
        .clk_in(clk), .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n), .io_in(hio),
        .io_out(io), .io_oe_out(oe), .wip_in(write_in_progress_flag), .soft_reset_in(srst),
        .deep_powerdown_out(dpd), .cmd_accept_out(acc));
    fpid_host i_host (.sclk_out(sclk), .cs_n_out(cs_n), .io_out(hio), .dev_io_in(io),
        .dev_oe_in(oe));
    always #2.5 clk = ~clk;
    function automatic logic [127:0] ex(input int k, input logic a, input int n);
        logic [127:0] s;
        logic [127:0] r;
        r = '0;
        s = k == 3 ? {MK, MT, CP} : k == 4 ? DV : k == 5 ? UID : a ? {DV, MK} : {MK, DV};
        for (int i = 0; i < n; i++) r = {r[126:0], s[ll[k] - 1 - i % ll[k]]};
        return r;
    endfunction
    task automatic chk(input string nm, input logic [127:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("Compares %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Bounded wait: a hang here is reported, not waited out
    task automatic wt(input logic w, input logic v);
        for (int n = 0; n < 1000 && (w ? dpd : acc) !== v; n++) @(posedge clk);
        chk("wait", w ? dpd : acc, v);
    endtask
    task automatic fr(input logic [7:0] op, input int n, h);
        i_host.frame(op, n, h, 1, 1'b0, got, oe_s);
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        got = $urandom(32'h40C8);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wt(1'b0, 1'b1);
        for (int k = 0; k < 12; k++) begin
            j = k % 6;
            a0 = j < 3 && k >= 6;
            nd = dc[j] + $urandom % 8;
            i_host.frame(ops[j], hd[j] + nd, hd[j], ln[j], a0, got, oe_s);
            chk("id", got, ex(j, a0, nd * ln[j]));
        end
        @(posedge clk);
        write_in_progress_flag <= 1'b1;
        fr(8'h9F, 32, 8);
        chk("ident_wip", oe_s, 1'b0);
        fr(8'hAB, 48, 32);
        chk("rel_wip", oe_s, 1'b0);
        fr(8'hB9, 8, 8);
        chk("dpd_wip", dpd, 1'b0);
        fr(8'h70, 8, 8);
        chk("rb_busy", io[1], 1'b0);
        write_in_progress_flag <= 1'b0;
        repeat (4) @(posedge clk);
        chk("rb_ready", io[1], 1'b1);
        fr(8'h80, 9, 9);
        chk("rb_kept", oe[1], 1'b1);
        fr(8'h80, 8, 8);
        chk("rb_off", oe[1], 1'b0);
        fr(8'hB9, 9, 9);
        chk("dpd_long", dpd, 1'b0);
        fr(8'hB9, 8, 8);
        wt(1'b1, 1'b1);
        fr(8'h90, 64, 32);
        chk("dpd_ign", oe_s, 1'b0);
        write_in_progress_flag <= 1'b1;
        fr(8'hAB, 8, 8);
        chk("rel_wip_dpd", dpd, 1'b1);
        write_in_progress_flag <= 1'b0;
        fr(8'hAB, 8, 8);
        chk("res1", acc, 1'b0);
        wt(1'b0, 1'b1);
        fr(8'hB9, 8, 8);
        wt(1'b1, 1'b1);
        fr(8'hAB, 48, 32);
        chk("res2", got, ex(4, 1'b0, 16));
        wt(1'b0, 1'b1);
        fr(8'hB9, 8, 8);
        wt(1'b1, 1'b1);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        wt(1'b0, 1'b1);
        end_sim();
    end
endmodule
